// ===== hct_defines.svh
`ifndef HCT_DEFINES_SVH
`define HCT_DEFINES_SVH

// four-character command codes as they sit in the command slot
`define HCT_CC_WARM 32'h47616964
`define HCT_CC_COLD 32'h47414944
`define HCT_CC_DETACH 32'h44495343
`define HCT_CC_CANCEL 32'h41425254
`define HCT_CC_LOCK 32'h4c4f434b
`define HCT_CC_MODAL_EXT 32'h4d4f4445
`define HCT_CC_REJECTED 32'h21434d44

// mode register tags
`define HCT_MODE_NORMAL 32'h41505020
`define HCT_MODE_DET_HI 24'h444953
`define HCT_MODE_EXT 32'h4d4f4445
`define HCT_PORT_ASCII_BASE 8'h30

// outcome byte fields and codes
`define HCT_OUT_LO 3
`define HCT_OUT_HI 7
`define HCT_RES_OK 4'h0
`define HCT_RES_ABORT 4'h1
`define HCT_RES_REJECT 4'h3

// reset values
`define HCT_SLOT_RST 32'h00000000
`define HCT_DATA_RST 32'h00000000
`define HCT_KEY_RST 32'h00000000
`define HCT_GCFG_RST 8'h00

// timing
`define HCT_CLK_PERIOD_NS 100
`define HCT_SECOND_NS 1000000000
`define HCT_SEC_CYCLES (`HCT_SECOND_NS / `HCT_CLK_PERIOD_NS)
`define HCT_RESTART_NAK_CYCLES 16

`endif

// ===== hct_engine.sv
// Summary of operation
// - outcome data written before slot clears
// - buffers untouched once slot reads zero
// - low nibble: 0 ok, 1 abort, 3 reject
// - upper nibble only kept on success
// - warm restart returns registers to defaults
// - cold restart also boots loader as it resets
// - refuse host accesses while restarting
// - one modal task; others rejected unless higher
// - modal mode value stays until exit, detach or restart
// - detach acts on own port, needs connection
// - delay byte in seconds, zero never reattaches
// - detach completes at once, replaces modal task
// - detached port disabled, no attach seen
// - detached tag with port; expiry restores normal
// - cancelled detach re-enables port immediately
// - cancel stops running task, outcome one
// - finished task overwrites cancel with zero
// - idle cancel clears slot, data untouched
// - lockable codes and guarded writes refused when locked
// - key copied only when current key unlocked
// - lock outcome from old and new key
`timescale 1ns/1ns
`include "hct_defines.svh"
`default_nettype none

module hct_engine #(
    parameter logic [31:0] SEC_CYCLES = `HCT_SEC_CYCLES,
    parameter logic [31:0] GATE_VALUE = 32'h0000a5c3
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [1:0] port_num,
    input wire logic port_connected_pin,
    input wire logic cmd_wr,
    input wire logic [31:0] cmd_wdata,
    input wire logic data_wr,
    input wire logic [3:0] data_be,
    input wire logic [31:0] data_wdata,
    input wire logic gcfg_wr,
    input wire logic [7:0] gcfg_wdata,
    input wire hct_pkg::hct_ext_rsp_t ext_rsp,
    output hct_pkg::hct_ext_req_t ext_req_q,
    output logic [31:0] command_slot_q,
    output logic [31:0] task_data_buffer_q,
    output logic [31:0] mode_q,
    output logic [7:0] gcfg_q,
    output logic locked_q,
    output logic port_disable_q,
    output logic conn_status_q,
    output logic disconnect_evt_q,
    output logic restart_q,
    output logic cold_boot_q,
    output logic nak_q
);
    import hct_pkg::*;

    function automatic logic key_open(input logic [31:0] k);
        key_open = (k == 32'h00000000) || (k == GATE_VALUE);
    endfunction : key_open

    // success keeps task detail; failures drop the upper nibble
    function automatic logic [7:0] outcome(input logic [7:0] r);
        outcome = (r[3:0] == `HCT_RES_OK) ? r : {4'h0, r[3:0]};
    endfunction : outcome

    hct_state_t state_q, state_d;
    logic [31:0] key_q, key_d, tick_q, tick_d;
    logic [7:0] delay_q, delay_d;
    logic [15:0] nak_cnt_q;
    logic det_q, det_d, conn_s1_q, conn_s2_q, cold_q;
    logic [31:0] slot_d, data_d, mode_d;

    ////////////////////////////////////////////////////////////////////////
    // connection pin synchroniser

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            conn_s1_q <= 1'b0;
            conn_s2_q <= 1'b0;
        end else if (clk_en) begin
            conn_s1_q <= port_connected_pin;
            conn_s2_q <= conn_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode, evaluated only while idle with a live code

    wire slot_live = command_slot_q != `HCT_SLOT_RST &&
        command_slot_q != `HCT_CC_REJECTED;
    wire go = state_q == HCT_ST_IDLE && slot_live;
    wire is_warm = go && command_slot_q == `HCT_CC_WARM;
    wire is_cold = go && command_slot_q == `HCT_CC_COLD;
    wire is_cancel = go && command_slot_q == `HCT_CC_CANCEL;
    wire is_det = go && command_slot_q == `HCT_CC_DETACH;
    wire is_lock = go && command_slot_q == `HCT_CC_LOCK;
    wire is_modal = go && command_slot_q == `HCT_CC_MODAL_EXT;
    wire is_fwd = go && !is_warm && !is_cold && !is_cancel && !is_det &&
        !is_lock && !is_modal;
    wire locked = !key_open(key_q);
    wire lockable = is_det || is_modal;
    wire lock_rej = lockable && locked;
    wire det_rej = is_det && !locked && !conn_s2_q;
    wire det_go = is_det && !locked && conn_s2_q;
    // a detach may be displaced by the higher-priority modal task
    wire mode_busy = mode_q != `HCT_MODE_NORMAL && !det_q;
    wire modal_rej = is_modal && !locked && mode_busy;
    wire modal_go = is_modal && !locked && !mode_busy;
    wire restart_go = is_warm || is_cold;
    // lock task: copy only from an open key, outcome from both keys
    wire key_take = is_lock && key_open(key_q);
    wire lock_ok = key_take && key_open(task_data_buffer_q);
    wire [3:0] lock_res = lock_ok ? `HCT_RES_OK : `HCT_RES_REJECT;

    ////////////////////////////////////////////////////////////////////////
    // outcome byte selection

    wire ext_done = state_q == HCT_ST_EXT && ext_rsp.done;
    wire [7:0] ext_out = ext_rsp.aborted ? {4'h0, `HCT_RES_ABORT} :
        outcome(ext_rsp.result);
    wire out_wr = det_go || det_rej || is_lock || modal_rej || ext_done;
    wire [7:0] out_byte = ext_done ? ext_out :
        is_lock ? {4'h0, lock_res} :
        (det_rej || modal_rej) ? {4'h0, `HCT_RES_REJECT} :
        {4'h0, `HCT_RES_OK};
    wire host_ok = !nak_q && state_q != HCT_ST_RST;
    wire to_fin = out_wr || is_cancel;

    ////////////////////////////////////////////////////////////////////////
    // detach timer: seconds prescaler and remaining delay

    wire timing = det_q && delay_q != 8'h00;
    wire sec_end = timing && tick_q == SEC_CYCLES - 32'h1;
    wire expire = sec_end && delay_q == 8'h01;
    wire det_cancel = det_q && modal_go;

    assign tick_d = (det_go || !timing || sec_end) ? 32'h0 :
        tick_q + 32'h1;
    assign delay_d = det_go ? task_data_buffer_q[7:0] :
        sec_end ? delay_q - 8'h01 : delay_q;
    assign det_d = restart_go ? 1'b0 : det_go ? 1'b1 :
        (expire || det_cancel) ? 1'b0 : det_q;

    ////////////////////////////////////////////////////////////////////////
    // next values of the host-visible registers

    assign mode_d = restart_go ? `HCT_MODE_NORMAL :
        det_go ? {`HCT_MODE_DET_HI, `HCT_PORT_ASCII_BASE +
        {6'h00, port_num}} :
        modal_go ? `HCT_MODE_EXT :
        expire ? `HCT_MODE_NORMAL :
        (ext_rsp.mode_exit && mode_q == `HCT_MODE_EXT) ?
        `HCT_MODE_NORMAL : mode_q;

    // a device clear always beats a late cancel from the host
    assign slot_d = restart_go ? `HCT_SLOT_RST :
        state_q == HCT_ST_FIN ? `HCT_SLOT_RST :
        lock_rej ? `HCT_CC_REJECTED :
        (cmd_wr && host_ok) ? cmd_wdata : command_slot_q;

    // host lanes first, then the device outcome byte on top
    always_comb begin
        data_d = task_data_buffer_q;
        if (data_wr && host_ok) begin
            for (int i = 0; i < 4; i++) begin
                if (data_be[i]) begin
                    data_d[i*8 +: 8] = data_wdata[i*8 +: 8];
                end
            end
        end
        if (out_wr) begin
            data_d[`HCT_OUT_HI:0] = out_byte;
        end
        if (restart_go) begin
            data_d = `HCT_DATA_RST;
        end
    end

    assign key_d = restart_go ? `HCT_KEY_RST :
        key_take ? task_data_buffer_q : key_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            HCT_ST_IDLE: begin
                if (restart_go) begin
                    state_d = HCT_ST_RST;
                end else if (to_fin) begin
                    state_d = HCT_ST_FIN;
                end else if (modal_go || is_fwd) begin
                    state_d = HCT_ST_EXT;
                end
            end
            HCT_ST_EXT: begin
                if (ext_done) begin
                    state_d = HCT_ST_FIN;
                end
            end
            HCT_ST_FIN: state_d = HCT_ST_IDLE;
            HCT_ST_RST: begin
                if (nak_cnt_q == 16'h0001) begin
                    state_d = HCT_ST_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control and buffer registers

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= HCT_ST_IDLE;
            command_slot_q <= `HCT_SLOT_RST;
            task_data_buffer_q <= `HCT_DATA_RST;
            mode_q <= `HCT_MODE_NORMAL;
            key_q <= `HCT_KEY_RST;
            det_q <= 1'b0;
            delay_q <= 8'h00;
            tick_q <= 32'h0;
        end else if (clk_en) begin
            state_q <= state_d;
            command_slot_q <= slot_d;
            task_data_buffer_q <= data_d;
            mode_q <= mode_d;
            key_q <= key_d;
            det_q <= det_d;
            delay_q <= delay_d;
            tick_q <= tick_d;
        end
    end

    // guarded configuration only accepts writes while unlocked
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            gcfg_q <= `HCT_GCFG_RST;
        end else if (clk_en) begin
            if (restart_go) begin
                gcfg_q <= `HCT_GCFG_RST;
            end else if (gcfg_wr && host_ok && !locked) begin
                gcfg_q <= gcfg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // restart sequencing: the nak window stands for a fixed count

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nak_cnt_q <= 16'h0;
            nak_q <= 1'b0;
            restart_q <= 1'b0;
            cold_q <= 1'b0;
            cold_boot_q <= 1'b0;
        end else if (clk_en) begin
            restart_q <= restart_go;
            cold_boot_q <= is_cold;
            cold_q <= is_cold ? 1'b1 : is_warm ? 1'b0 : cold_q;
            if (restart_go) begin
                nak_cnt_q <= 16'(`HCT_RESTART_NAK_CYCLES);
                nak_q <= 1'b1;
            end else if (nak_cnt_q != 16'h0) begin
                nak_cnt_q <= nak_cnt_q - 16'h1;
                nak_q <= nak_cnt_q != 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external task hand-off and port status outputs

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ext_req_q <= '0;
            locked_q <= 1'b0;
            port_disable_q <= 1'b0;
            conn_status_q <= 1'b0;
            disconnect_evt_q <= 1'b0;
        end else if (clk_en) begin
            ext_req_q.start <= modal_go || is_fwd;
            ext_req_q.code <= go ? command_slot_q : ext_req_q.code;
            // cancel is seen only while the task is still running
            ext_req_q.abort <= state_d == HCT_ST_EXT &&
                slot_d == `HCT_CC_CANCEL;
            locked_q <= !key_open(key_d);
            port_disable_q <= det_d;
            conn_status_q <= conn_s2_q && !det_d;
            disconnect_evt_q <= det_go;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic [7:0] sec_seen_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n || !det_q || det_go) begin
            sec_seen_q <= 8'h00;
        end else if (clk_en && sec_end) begin
            sec_seen_q <= sec_seen_q + 8'h01;
        end
    end

    a_slot_after_data: assert property (
        clk_en && state_q == HCT_ST_FIN |=> command_slot_q == 32'h0 &&
        task_data_buffer_q == $past(task_data_buffer_q))
        else $error("slot cleared with changing data");
    a_idle_data_hold: assert property (
        clk_en && state_q == HCT_ST_IDLE && !go && !(data_wr && host_ok)
        |=> task_data_buffer_q == $past(task_data_buffer_q))
        else $error("device touched buffer after completion");
    a_lo_nibble_code: assert property (
        clk_en && (det_rej || modal_rej) |=>
        task_data_buffer_q[3:0] == 4'h3 && state_q == HCT_ST_FIN)
        else $error("rejection outcome wrong");
    a_hi_nibble_clear: assert property (
        clk_en && ext_done && ext_rsp.result[3:0] != 4'h0 |=>
        task_data_buffer_q[7:4] == 4'h0)
        else $error("detail kept on failed task");
    a_restart_defaults: assert property (
        clk_en && restart_go |=> command_slot_q == 32'h0 &&
        task_data_buffer_q == 32'h0 && mode_q == `HCT_MODE_NORMAL &&
        restart_q && nak_q)
        else $error("restart did not restore defaults");
    a_cold_flag: assert property (
        clk_en && is_cold |=> cold_boot_q && restart_q)
        else $error("cold restart not flagged");
    a_nak_window: assert property (
        clk_en && restart_go |=> nak_q && state_q == HCT_ST_RST)
        else $error("restart window missing");
    a_modal_reject: assert property (
        clk_en && is_modal && !locked && mode_q == `HCT_MODE_EXT |=>
        mode_q == `HCT_MODE_EXT && !ext_req_q.start)
        else $error("second modal task started");
    a_det_tag: assert property (
        clk_en && det_go |=> mode_q[31:8] == `HCT_MODE_DET_HI &&
        port_disable_q && disconnect_evt_q && !conn_status_q)
        else $error("detach state wrong");
    a_det_zero_delay: assert property (
        det_q && delay_q == 8'h00 |-> sec_seen_q == 8'h00 && !expire)
        else $error("zero delay reattached");
    a_det_cancel: assert property (
        clk_en && det_cancel |=> !det_q && !port_disable_q)
        else $error("cancelled detach kept port off");
    a_idle_cancel: assert property (
        clk_en && is_cancel |=> state_q == HCT_ST_FIN ##1
        command_slot_q == 32'h0 && $stable(task_data_buffer_q))
        else $error("idle cancel mishandled");
    a_lock_gate: assert property (
        clk_en && lock_rej |=> command_slot_q == `HCT_CC_REJECTED)
        else $error("locked command not refused");
    a_key_ignore: assert property (
        clk_en && is_lock && locked |=> key_q == $past(key_q) &&
        task_data_buffer_q[3:0] == 4'h3)
        else $error("locked key overwritten");

    c_detach_expire: cover property (clk_en && expire);
    c_ext_abort: cover property (ext_done && ext_rsp.aborted);
    c_lock_ok: cover property (clk_en && lock_ok);
    c_restart: cover property (clk_en && is_warm);

endmodule : hct_engine

`default_nettype wire

// ===== hct_engine_tb.sv
`timescale 1ns/1ns
`include "hct_defines.svh"
`default_nettype none

module hct_engine_tb;
    import hct_pkg::*;

    // a short second keeps the reattach timer inside the run
    localparam logic [31:0] SEC = 32'h00000014;
    localparam logic [31:0] GATE = 32'h0000a5c3;
    localparam logic [31:0] LONG = 32'h53574150;
    logic core_clk, rst_n, conn, cmd_wr, data_wr, gcfg_wr, ign, exit_req;
    logic [3:0] data_be;
    logic [31:0] cmd_wdata, data_wdata, slot, data, mode;
    logic [7:0] gcfg_wdata, lat, res, gcfg;
    logic locked, pdis, cstat, devt, rst_p, cold, nak, ce;
    hct_ext_req_t req;
    hct_ext_rsp_t rsp;
    int err_total = 0;
    int num_checks = 0;
    int n_cold = 0;
    int n_rst = 0;
    int n_evt = 0;

    hct_engine #(.SEC_CYCLES(SEC), .GATE_VALUE(GATE)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(ce),
        .port_num(2'h1), .port_connected_pin(conn), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata), .data_wr(data_wr), .data_be(data_be),
        .data_wdata(data_wdata), .gcfg_wr(gcfg_wr), .gcfg_wdata(gcfg_wdata),
        .ext_rsp(rsp), .ext_req_q(req), .command_slot_q(slot),
        .task_data_buffer_q(data), .mode_q(mode), .gcfg_q(gcfg),
        .locked_q(locked), .port_disable_q(pdis), .conn_status_q(cstat),
        .disconnect_evt_q(devt), .restart_q(rst_p), .cold_boot_q(cold),
        .nak_q(nak));

    hct_ext_model i_ext (
        .core_clk(core_clk), .rst_n(rst_n), .ext_req_q(req), .lat(lat),
        .res(res), .ign_abort(ign), .exit_req(exit_req), .ext_rsp(rsp));

    ////////////////////////////////////////////////////////////////////////
    // clock, restart and detach strobe counters
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // counted on the falling edge, well away from the launching edge
    always @(negedge core_clk) begin
        if (cold === 1'b1) n_cold++;
        if (rst_p === 1'b1) n_rst++;
        if (devt === 1'b1) n_evt++;
    end

    ////////////////////////////////////////////////////////////////////////
    // host access tasks, each drive lands just after a rising edge
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic put_data(input logic [31:0] v);
        @(posedge core_clk);
        data_wr <= 1'b1;
        data_be <= 4'hf;
        data_wdata <= v;
        @(posedge core_clk);
        data_wr <= 1'b0;
    endtask : put_data

    task automatic put_cfg(input logic [7:0] v);
        @(posedge core_clk);
        gcfg_wr <= 1'b1;
        gcfg_wdata <= v;
        @(posedge core_clk);
        gcfg_wr <= 1'b0;
    endtask : put_cfg

    task automatic issue(input logic [31:0] code);
        @(posedge core_clk);
        cmd_wr <= 1'b1;
        cmd_wdata <= code;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
    endtask : issue

    // bounded wait until the slot is free again and the host is heard
    task automatic wait_free;
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((slot !== 32'h0 && slot !== `HCT_CC_REJECTED ||
                    nak !== 1'b0) && n < 300);
        chk(n < 300, 1'b1, "command never completed");
    endtask : wait_free

    task automatic run_cmd(input logic [31:0] code);
        issue(code);
        wait_free();
    endtask : run_cmd

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        rst_n = 1'b0;
        {conn, cmd_wr, data_wr, gcfg_wr, ign, exit_req} = 6'h00;
        ce = 1'b1;
        {data_be, cmd_wdata, data_wdata, gcfg_wdata, res} = '0;
        lat = 8'h04;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk(mode, `HCT_MODE_NORMAL, "mode at reset");
        chk(slot, 32'h0, "slot at reset");
        chk(data, 32'h0, "buffer at reset");
        chk({locked, pdis, devt, rst_p, nak, gcfg}, '0, "reset flags");
        put_cfg(8'h3c);
        @(negedge core_clk);
        chk(gcfg, 8'h3c, "guarded write open");
        $display("test reset done");
        put_data(32'h00000005);
        run_cmd(`HCT_CC_DETACH);
        chk(data[7:0], `HCT_RES_REJECT, "detach unconnected");
        chk(mode, `HCT_MODE_NORMAL, "mode kept");
        @(posedge core_clk);
        conn <= 1'b1;
        put_data(32'h00000002);
        run_cmd(`HCT_CC_DETACH);
        chk(data[7:0], `HCT_RES_OK, "detach outcome");
        chk(mode, {`HCT_MODE_DET_HI, 8'h31}, "detached tag");
        chk({pdis, cstat}, 2'b10, "port disabled");
        repeat (30) @(negedge core_clk);
        chk(mode, {`HCT_MODE_DET_HI, 8'h31}, "tag before expiry");
        repeat (20) @(negedge core_clk);
        chk(mode, `HCT_MODE_NORMAL, "tag after expiry");
        chk({pdis, cstat}, 2'b01, "port resumed");
        chk(data[7:0], `HCT_RES_OK, "buffer kept");
        $display("test detach timed done");
        put_data(32'h00000000);
        run_cmd(`HCT_CC_DETACH);
        repeat (60) @(negedge core_clk);
        chk(mode, {`HCT_MODE_DET_HI, 8'h31}, "no reattach");
        lat <= 8'h06;
        res <= 8'h50;
        issue(`HCT_CC_MODAL_EXT);
        repeat (2) @(negedge core_clk);
        chk(pdis, 1'b0, "cancelled detach");
        chk(mode, `HCT_MODE_EXT, "modal tag");
        wait_free();
        chk(data[7:0], 8'h50, "success detail");
        run_cmd(`HCT_CC_MODAL_EXT);
        chk(data[7:0], `HCT_RES_REJECT, "second modal");
        res <= 8'h52;
        run_cmd(LONG);
        chk(data[7:0], 8'h02, "detail dropped");
        chk(mode, `HCT_MODE_EXT, "mode persists");
        @(posedge core_clk);
        exit_req <= 1'b1;
        @(posedge core_clk);
        exit_req <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk(mode, `HCT_MODE_NORMAL, "modal exit");
        $display("test modal done");
        lat <= 8'h64;
        issue(LONG);
        issue(`HCT_CC_CANCEL);
        @(negedge core_clk);
        chk(slot, `HCT_CC_CANCEL, "cancel stays");
        wait_free();
        chk(data[7:0], `HCT_RES_ABORT, "aborted outcome");
        {ign, lat, res} <= {1'b1, 8'h0a, 8'h00};
        issue(LONG);
        issue(`HCT_CC_CANCEL);
        @(negedge core_clk);
        chk(slot, `HCT_CC_CANCEL, "cancel unseen");
        wait_free();
        chk(data[7:0], `HCT_RES_OK, "normal finish");
        ign <= 1'b0;
        put_data(32'h12345678);
        run_cmd(`HCT_CC_CANCEL);
        chk(data, 32'h12345678, "idle cancel");
        $display("test cancel done");
        put_data(32'h11112222);
        run_cmd(`HCT_CC_LOCK);
        chk(data[7:0], `HCT_RES_REJECT, "locking key");
        chk(locked, 1'b1, "now locked");
        put_cfg(8'hc3);
        @(negedge core_clk);
        chk(gcfg, 8'h3c, "guarded write shut");
        put_data(32'h00000002);
        run_cmd(`HCT_CC_DETACH);
        chk(slot, `HCT_CC_REJECTED, "lockable code");
        chk(data, 32'h00000002, "refusal untouched");
        put_data(GATE);
        run_cmd(`HCT_CC_LOCK);
        chk({data[7:0], locked}, 9'h007, "key ignored");
        issue(`HCT_CC_WARM);
        repeat (3) @(negedge core_clk);
        chk(nak, 1'b1, "refusing host");
        chk(slot, 32'h0, "warm slot");
        chk(data, 32'h0, "warm buffer");
        chk({locked, gcfg}, '0, "warm key and config");
        chk(n_rst, 1, "restart strobe");
        put_data(32'h00000077);
        wait_free();
        chk(data, 32'h0, "write refused");
        put_data(GATE);
        run_cmd(`HCT_CC_LOCK);
        chk({data[7:0], locked}, 9'h000, "unlock key");
        // a host write while the enable is low must not land
        @(posedge core_clk);
        ce <= 1'b0;
        put_data(32'h0000abcd);
        repeat (2) @(negedge core_clk);
        chk(data, {GATE[31:8], 8'h00}, "frozen by enable");
        @(posedge core_clk);
        ce <= 1'b1;
        $display("test lock done");
        lat <= 8'h03;
        run_cmd(`HCT_CC_MODAL_EXT);
        run_cmd(`HCT_CC_COLD);
        chk(mode, `HCT_MODE_NORMAL, "cold clears mode");
        chk(n_cold, 1, "cold strobe");
        chk(n_rst, 2, "restart strobes");
        chk(n_evt, 2, "detach events");
        chk(slot, 32'h0, "cold complete");
        $display("test restart done");
        stop_test();
    end

endmodule : hct_engine_tb
`default_nettype wire

// ===== hct_ext_model.sv
`timescale 1ns/1ns
`include "hct_defines.svh"
`default_nettype none

// far-side engine for forwarded long tasks, latency and result set per run
module hct_ext_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire hct_pkg::hct_ext_req_t ext_req_q,
    input wire logic [7:0] lat,
    input wire logic [7:0] res,
    input wire logic ign_abort,
    input wire logic exit_req,
    output hct_pkg::hct_ext_rsp_t ext_rsp
);
    import hct_pkg::*;

    logic busy_q;
    logic [7:0] cnt_q;
    logic stop_w;
    logic fin_w;

    ////////////////////////////////////////////////////////////////////////
    // a cancel is seen at any running cycle unless told to miss it
    assign stop_w = busy_q && ext_req_q.abort && !ign_abort;
    assign fin_w = busy_q && (cnt_q == 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // aborted and result fields flip every cycle between answers so stale values do not hold still
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            ext_rsp <= '0;
        end else begin
            ext_rsp.done <= stop_w || fin_w;
            ext_rsp.mode_exit <= exit_req;
            if (stop_w || fin_w) begin
                busy_q <= 1'b0;
                ext_rsp.aborted <= stop_w;
                ext_rsp.result <= stop_w ? 8'h01 : res;
            end else begin
                ext_rsp.aborted <= ~ext_rsp.aborted;
                ext_rsp.result <= ~ext_rsp.result;
            end
            if (ext_req_q.start) begin
                busy_q <= 1'b1;
                cnt_q <= lat;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

endmodule : hct_ext_model
`default_nettype wire

// ===== hct_pkg.sv
`default_nettype none
package hct_pkg;

    typedef enum logic [1:0] {
        HCT_ST_IDLE = 2'b00,
        HCT_ST_EXT = 2'b01,
        HCT_ST_FIN = 2'b10,
        HCT_ST_RST = 2'b11
    } hct_state_t;

    // request to the engine that runs forwarded long tasks
    typedef struct packed {
        logic start;
        logic abort;
        logic [31:0] code;
    } hct_ext_req_t;

    // answer from that engine
    typedef struct packed {
        logic done;
        logic aborted;
        logic mode_exit;
        logic [7:0] result;
    } hct_ext_rsp_t;

endpackage : hct_pkg
`default_nettype wire
